// ==== hw/mcpwm_pkg.sv ====
/*
 * mcpwm_pkg: register map, field positions, reset values and widths shared
 * by the multi-channel pwm timer and its counter.
 * assumes a 32-bit avalon-mm slave with byte addresses, one word per register.
 */
package mcpwm_pkg;
	localparam int unsigned MCPWM_DW      = 32;
	localparam int unsigned MCPWM_AW      = 8;
	localparam int unsigned MCPWM_NMATCH  = 7;
	localparam int unsigned MCPWM_NOUT    = 6;

	// register byte offsets
	localparam logic [7:0] MCPWM_CTRL_OFS     = 8'h00;
	localparam logic [7:0] MCPWM_COUNT_OFS    = 8'h04;
	localparam logic [7:0] MCPWM_PRESCALE_OFS = 8'h08;
	localparam logic [7:0] MCPWM_PRECNT_OFS   = 8'h0C;
	localparam logic [7:0] MCPWM_MATCH0_OFS   = 8'h10;
	localparam logic [7:0] MCPWM_ACTION_OFS   = 8'h2C;
	localparam logic [7:0] MCPWM_OUTSEL_OFS   = 8'h30;
	localparam logic [7:0] MCPWM_RELEASE_OFS  = 8'h34;
	localparam logic [7:0] MCPWM_STATUS_OFS   = 8'h38;
	localparam logic [7:0] MCPWM_MASK_OFS     = 8'h3C;

	// control register fields
	localparam int unsigned MCPWM_CTRL_RUN    = 0;
	localparam int unsigned MCPWM_CTRL_CLEAR  = 1;
	localparam int unsigned MCPWM_CTRL_PWM    = 2;
	localparam int unsigned MCPWM_CTRL_MODE   = 3;
	localparam int unsigned MCPWM_CTRL_CAPSEL = 5;
	localparam int unsigned MCPWM_CTRL_W      = 6;
	localparam logic [5:0]  MCPWM_CTRL_RST    = 6'h00;

	// count source modes in ctrl[4:3]
	localparam logic [1:0] MCPWM_MODE_TIMER = 2'h0;
	localparam logic [1:0] MCPWM_MODE_RISE  = 2'h1;
	localparam logic [1:0] MCPWM_MODE_FALL  = 2'h2;
	localparam logic [1:0] MCPWM_MODE_BOTH  = 2'h3;

	// match action: three bits per match channel
	localparam int unsigned MCPWM_ACT_INT   = 0;
	localparam int unsigned MCPWM_ACT_RESET = 1;
	localparam int unsigned MCPWM_ACT_STOP  = 2;
	localparam int unsigned MCPWM_ACT_W     = 3;

	// output select: double-edge bits at [6:2], output enables at [14:9]
	localparam int unsigned MCPWM_SEL_DBL   = 0;
	localparam int unsigned MCPWM_SEL_ENA   = 8;

	localparam logic [31:0] MCPWM_MATCH_RST = 32'h0000_0000;
	localparam logic [31:0] MCPWM_ZERO      = 32'h0000_0000;
endpackage

// ==== hw/mcpwm_count.sv ====
/*
 * mcpwm_count: 32-bit prescaler and 32-bit timer count.
 * assumes advance is a one-cycle enable from the same clock domain and that
 * the caller decides the match reset from the count it sees.
 */
`timescale 1ns/1ps
module mcpwm_count
	import mcpwm_pkg::*;
(
	// clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 resetn,
	// control
	input  wire logic                 run,
	input  wire logic                 advance,
	input  wire logic                 sw_clear,
	input  wire logic                 match_reset,
	input  wire logic [MCPWM_DW-1:0]  pre_limit,
	// software loads
	input  wire logic                 ld_count,
	input  wire logic                 ld_pre,
	input  wire logic [MCPWM_DW-1:0]  wdata,
	// state
	output logic      [MCPWM_DW-1:0]  count_q,
	output logic      [MCPWM_DW-1:0]  pre_q,
	output logic                      tick
);
	assign tick = run && advance && (pre_q == pre_limit);

	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			count_q <= MCPWM_ZERO;
			pre_q   <= MCPWM_ZERO;
		end
		else if (sw_clear)
		begin
			count_q <= MCPWM_ZERO;
			pre_q   <= MCPWM_ZERO;
		end
		else
		begin
			if (ld_count)
				count_q <= wdata;
			else if (tick)
				count_q <= match_reset ? MCPWM_ZERO : count_q + 32'h0000_0001;
			if (ld_pre)
				pre_q <= wdata;
			else if (tick)
				pre_q <= MCPWM_ZERO;
			else if (run && advance)
				pre_q <= pre_q + 32'h0000_0001;
		end
	end
endmodule

// ==== hw/mcpwm_top.sv ====
/*
 * mcpwm_top: multi-channel pwm timer with seven match registers, six pwm
 * outputs, match actions, shadowed match values and a masked interrupt.
 * assumes one 40 MHz clock, a synchronous active-low reset, an avalon-mm
 * master on the register port and asynchronous capture pins.
 */
// Operation
// - seven match registers compared with the count, each able to act.
// - match on cycle_period_match resets the count, setting the common period.
// - single-edge output rises at period match, falls at own match, zero stays low.
// - double-edge output uses two match registers plus the period register.
// - rise before fall gives positive pulse, fall first gives negative pulse.
// - six single-edge, three double-edge, or a mix, from seven matches.
// - per match: continue, stop or reset, each optionally interrupting.
// - double-edge edges may sit at any count inside the cycle.
// - period and width are any whole counts, all outputs share the rate.
// - released match values apply only at period boundary, avoiding glitches.
// - without pwm mode, a plain timer with match actions, outputs idle.
// - 32-bit count advanced through a programmable 32-bit prescaler.
// - counts the clock, or edges of a selected capture input.
`timescale 1ns/1ps
module mcpwm_top
	import mcpwm_pkg::*;
(
	// clock and reset
	input  wire logic                     ref_clk,
	input  wire logic                     resetn,
	// avalon-mm slave
	input  wire logic [MCPWM_AW-1:0]      avs_address,
	input  wire logic                     avs_read,
	input  wire logic                     avs_write,
	input  wire logic [MCPWM_DW-1:0]      avs_writedata,
	output logic      [MCPWM_DW-1:0]      avs_readdata,
	output logic                          avs_waitrequest,
	// capture pins
	input  wire logic [1:0]               cap_in,
	// pwm outputs and interrupt
	output logic      [MCPWM_NOUT:1]      pwm_out,
	output logic                          irq
);
	import mcpwm_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// registers

	logic [MCPWM_CTRL_W-1:0]              ctrl_q;
	logic [MCPWM_DW-1:0]                  prescale_q;
	logic [MCPWM_DW-1:0]                  shadow_q [MCPWM_NMATCH];
	logic [MCPWM_DW-1:0]                  match_q  [MCPWM_NMATCH];
	logic [MCPWM_NMATCH*MCPWM_ACT_W-1:0]  action_q;
	logic [15:0]                          outsel_q;
	logic [MCPWM_NMATCH-1:0]              release_q;
	logic [MCPWM_NMATCH-1:0]              status_q;
	logic [MCPWM_NMATCH-1:0]              mask_q;
	logic [1:0]                           cap_s1_q;
	logic [1:0]                           cap_s2_q;
	logic [1:0]                           cap_s3_q;

	logic                                 acc;
	logic                                 wr_acc;
	logic                                 rd_acc;
	logic [MCPWM_DW-1:0]                  count;
	logic [MCPWM_DW-1:0]                  pre;
	logic                                 tick;
	logic                                 advance;
	logic [MCPWM_NMATCH-1:0]              hit;
	logic                                 do_reset;
	logic                                 do_stop;
	logic                                 period_hit;
	logic [MCPWM_DW-1:0]                  rdata;
	logic [MCPWM_NOUT:1]                  set_ev;

	function automatic logic is_match_ofs(input logic [7:0] a, input int unsigned i);
		is_match_ofs = (a == MCPWM_MATCH0_OFS + 8'(4 * i));
	endfunction

	function automatic logic act_bit(input logic [MCPWM_NMATCH*MCPWM_ACT_W-1:0] a,
		input int unsigned ch, input int unsigned b);
		act_bit = a[ch * MCPWM_ACT_W + b];
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// bus handshake: one wait state, then the access completes

	assign acc    = (avs_read || avs_write) && !avs_waitrequest;
	assign wr_acc = acc && avs_write;
	assign rd_acc = acc && avs_read;

	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			avs_waitrequest <= 1'b1;
		else if ((avs_read || avs_write) && avs_waitrequest)
			avs_waitrequest <= 1'b0;
		else
			avs_waitrequest <= 1'b1;
	end

	always_comb
	begin
		rdata = MCPWM_ZERO;
		case (avs_address)
			MCPWM_CTRL_OFS:     rdata = {26'h0, ctrl_q};
			MCPWM_COUNT_OFS:    rdata = count;
			MCPWM_PRESCALE_OFS: rdata = prescale_q;
			MCPWM_PRECNT_OFS:   rdata = pre;
			MCPWM_ACTION_OFS:   rdata = {11'h0, action_q};
			MCPWM_OUTSEL_OFS:   rdata = {16'h0, outsel_q};
			MCPWM_RELEASE_OFS:  rdata = {25'h0, release_q};
			MCPWM_STATUS_OFS:   rdata = {25'h0, status_q};
			MCPWM_MASK_OFS:     rdata = {25'h0, mask_q};
			default:
			begin
				for (int i = 0; i < MCPWM_NMATCH; i++)
					if (is_match_ofs(avs_address, i))
						rdata = shadow_q[i];
			end
		endcase
	end

	// read data loaded while waitrequest is still high, stands at the completing edge
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			avs_readdata <= MCPWM_ZERO;
		else if (avs_read && avs_waitrequest)
			avs_readdata <= rdata;
	end

	////////////////////////////////////////////////////////////////////////////
	// control: stop action clears run, clear bit is self-resetting

	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			ctrl_q <= MCPWM_CTRL_RST;
		else
		begin
			if (wr_acc && avs_address == MCPWM_CTRL_OFS)
				ctrl_q <= avs_writedata[MCPWM_CTRL_W-1:0];
			else
				ctrl_q[MCPWM_CTRL_CLEAR] <= 1'b0;
			if (do_stop)
				ctrl_q[MCPWM_CTRL_RUN] <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			prescale_q <= MCPWM_ZERO;
			action_q   <= '0;
			outsel_q   <= 16'h0000;
			mask_q     <= '0;
		end
		else if (wr_acc)
		begin
			if (avs_address == MCPWM_PRESCALE_OFS)
				prescale_q <= avs_writedata;
			if (avs_address == MCPWM_ACTION_OFS)
				action_q <= avs_writedata[MCPWM_NMATCH*MCPWM_ACT_W-1:0];
			if (avs_address == MCPWM_OUTSEL_OFS)
				outsel_q <= avs_writedata[15:0];
			if (avs_address == MCPWM_MASK_OFS)
				mask_q <= avs_writedata[MCPWM_NMATCH-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// count source: clock or synchronised capture edges

	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			cap_s1_q <= 2'h0;
			cap_s2_q <= 2'h0;
			cap_s3_q <= 2'h0;
		end
		else
		begin
			cap_s1_q <= cap_in;
			cap_s2_q <= cap_s1_q;
			cap_s3_q <= cap_s2_q;
		end
	end

	always_comb
	begin
		logic now;
		logic old;
		now = cap_s2_q[ctrl_q[MCPWM_CTRL_CAPSEL]];
		old = cap_s3_q[ctrl_q[MCPWM_CTRL_CAPSEL]];
		case (ctrl_q[MCPWM_CTRL_MODE+:2])
			MCPWM_MODE_TIMER: advance = 1'b1;
			MCPWM_MODE_RISE:  advance = now && !old;
			MCPWM_MODE_FALL:  advance = !now && old;
			MCPWM_MODE_BOTH:  advance = now ^ old;
			default:          advance = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// match compare and actions

	always_comb
	begin
		do_reset = 1'b0;
		do_stop  = 1'b0;
		for (int i = 0; i < MCPWM_NMATCH; i++)
		begin
			hit[i] = tick && (count == match_q[i]);
			if (hit[i] && act_bit(action_q, i, MCPWM_ACT_RESET))
				do_reset = 1'b1;
			if (hit[i] && act_bit(action_q, i, MCPWM_ACT_STOP))
				do_stop = 1'b1;
		end
		if (ctrl_q[MCPWM_CTRL_PWM] && hit[0])
			do_reset = 1'b1;
	end

	assign period_hit = hit[0];

	mcpwm_count u_count (
		.ref_clk     (ref_clk),
		.resetn      (resetn),
		.run         (ctrl_q[MCPWM_CTRL_RUN]),
		.advance     (advance),
		.sw_clear    (ctrl_q[MCPWM_CTRL_CLEAR]),
		.match_reset (do_reset),
		.pre_limit   (prescale_q),
		.ld_count    (wr_acc && avs_address == MCPWM_COUNT_OFS),
		.ld_pre      (wr_acc && avs_address == MCPWM_PRECNT_OFS),
		.wdata       (avs_writedata),
		.count_q     (count),
		.pre_q       (pre),
		.tick        (tick)
	);

	////////////////////////////////////////////////////////////////////////////
	// shadowed match values, released values applied at the period boundary

	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			for (int i = 0; i < MCPWM_NMATCH; i++)
			begin
				shadow_q[i] <= MCPWM_MATCH_RST;
				match_q[i]  <= MCPWM_MATCH_RST;
			end
		else
			for (int i = 0; i < MCPWM_NMATCH; i++)
			begin
				if (wr_acc && is_match_ofs(avs_address, i))
					shadow_q[i] <= avs_writedata;
				if (!ctrl_q[MCPWM_CTRL_PWM])
					match_q[i] <= shadow_q[i];
				else if (period_hit && release_q[i])
					match_q[i] <= shadow_q[i];
			end
	end

	// software sets release bits, hardware clears them once applied; set wins
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			release_q <= '0;
		else
		begin
			if (!ctrl_q[MCPWM_CTRL_PWM])
				release_q <= '0;
			else if (period_hit)
				release_q <= '0;
			if (wr_acc && avs_address == MCPWM_RELEASE_OFS)
				release_q <= (period_hit ? {MCPWM_NMATCH{1'b0}} : release_q)
					| avs_writedata[MCPWM_NMATCH-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pwm outputs

	always_comb
	begin
		for (int n = 1; n <= MCPWM_NOUT; n++)
			if ((n >= 2) && outsel_q[MCPWM_SEL_DBL + n])
				set_ev[n] = hit[n-1];
			else
				set_ev[n] = hit[0] && (match_q[n] != MCPWM_ZERO);
	end

	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			pwm_out <= '0;
		else
			for (int n = 1; n <= MCPWM_NOUT; n++)
			begin
				if (!ctrl_q[MCPWM_CTRL_PWM] || !outsel_q[MCPWM_SEL_ENA + n])
					pwm_out[n] <= 1'b0;
				else if (hit[n])
					pwm_out[n] <= 1'b0;
				else if (set_ev[n])
					pwm_out[n] <= 1'b1;
			end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupt status: sticky, cleared by a status read, set wins

	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			status_q <= '0;
		else
			for (int i = 0; i < MCPWM_NMATCH; i++)
			begin
				if (hit[i] && act_bit(action_q, i, MCPWM_ACT_INT))
					status_q[i] <= 1'b1;
				else if (rd_acc && avs_address == MCPWM_STATUS_OFS)
					status_q[i] <= 1'b0;
			end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			irq <= 1'b0;
		else
			irq <= |(status_q & mask_q);
	end
endmodule

// ==== verif/mcpwm_top_assertions.sv ====
/*
 * mcpwm_top_assertions: bus, output and interrupt checks on the top ports.
 * assumes one clock and a master that holds each request until answered.
 */
`timescale 1ns/1ps
module mcpwm_checker
	import mcpwm_pkg::*;
(
	// clock and reset
	input wire logic                ref_clk,
	input wire logic                resetn,
	// register bus
	input wire logic [MCPWM_AW-1:0] avs_address,
	input wire logic                avs_read,
	input wire logic                avs_write,
	input wire logic [MCPWM_DW-1:0] avs_writedata,
	input wire logic [MCPWM_DW-1:0] avs_readdata,
	input wire logic                avs_waitrequest,
	// pins
	input wire logic [1:0]          cap_in,
	input wire logic [MCPWM_NOUT:1] pwm_out,
	input wire logic                irq
);
	default clocking @(posedge ref_clk); endclocking
	logic       pwm_q;
	logic [6:1] ena_q;
	logic [6:0] mask_q;
	logic [6:1] en_now;
	logic       wr_done;
	assign wr_done = avs_write && !avs_waitrequest;
	assign en_now = pwm_q ? ena_q : 6'h00;
	////////////////////////////////////////////////////////////////////////////
	// shadow of the control, output select and mask words
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			pwm_q <= 1'b0;
			ena_q <= 6'h00;
			mask_q <= 7'h00;
		end
		else if (wr_done)
		begin
			if (avs_address == MCPWM_CTRL_OFS)
				pwm_q <= avs_writedata[MCPWM_CTRL_PWM];
			if (avs_address == MCPWM_OUTSEL_OFS)
				ena_q <= avs_writedata[14:9];
			if (avs_address == MCPWM_MASK_OFS)
				mask_q <= avs_writedata[6:0];
		end
	end
	////////////////////////////////////////////////////////////////////////////
	sequence s_req;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_ack;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence
	req_answer_a: assert property (disable iff (!resetn) s_req |=> s_ack)
		else $error("request not answered by a one cycle wait release");
	answer_cause_a: assert property (disable iff (!resetn)
		!avs_waitrequest |-> $past(avs_read || avs_write))
		else $error("wait released without a request");
	idle_wait_a: assert property (disable iff (!resetn)
		(!avs_read && !avs_write) |=> avs_waitrequest)
		else $error("wait released while idle");
	reset_quiet_a: assert property (!resetn |=> avs_waitrequest && !irq
		&& pwm_out == 6'h00 && avs_readdata == 32'h0000_0000)
		else $error("outputs not quiet in reset");
	rdata_hold_a: assert property (disable iff (!resetn)
		$changed(avs_readdata) |-> $past(avs_read && avs_waitrequest))
		else $error("read data changed outside a read");
	pwm_off_a: assert property (
		disable iff (!resetn) (!pwm_q) [*3] |-> pwm_out == 6'h00)
		else $error("output active with pwm mode off");
	out_enable_a: assert property (
		disable iff (!resetn) pwm_out != 6'h00
		|-> (pwm_out & ~($past(en_now) | $past(en_now, 2))) == 6'h00)
		else $error("disabled output active");
	irq_mask_a: assert property (
		disable iff (!resetn) (mask_q == 7'h00) [*2] |-> !irq)
		else $error("interrupt with all sources masked");
endmodule
bind mcpwm_top mcpwm_checker i_chk (.ref_clk, .resetn, .avs_address, .avs_read,
	.avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .cap_in,
	.pwm_out, .irq);

// ==== verif/mcpwm_load.sv ====
/*
 * mcpwm_load: pwm load that measures period and high time of each output.
 * assumes outputs are registered levels on ref_clk.
 */
`timescale 1ns/1ps
module mcpwm_load
(
	// clock
	input wire logic              ref_clk,
	// pwm pins
	input wire logic [6:1]        pwm_out,
	// rise to rise and high span, in clock cycles
	output logic     [6:1][31:0]  per_q,
	output logic     [6:1][31:0]  hi_q
);
	logic [6:1][31:0] cyc_q = '0;
	logic [6:1][31:0] hcnt_q = '0;
	logic [6:1][31:0] per_r = '0;
	logic [6:1][31:0] hi_r = '0;
	logic [6:1]       last_q = 6'h00;
	assign per_q = per_r;
	assign hi_q = hi_r;
	always @(posedge ref_clk)
	begin
		for (int n = 1; n <= 6; n++)
		begin
			if (pwm_out[n] && !last_q[n])
			begin
				per_r[n] <= cyc_q[n];
				cyc_q[n] <= 32'h0000_0001;
			end
			else
				cyc_q[n] <= cyc_q[n] + 32'h0000_0001;
			if (pwm_out[n])
				hcnt_q[n] <= hcnt_q[n] + 32'h0000_0001;
			else if (last_q[n])
			begin
				hi_r[n] <= hcnt_q[n];
				hcnt_q[n] <= 32'h0000_0000;
			end
		end
		last_q <= pwm_out;
	end
endmodule

// ==== verif/test_multi_channel_pwm_timer.sv ====
/*
 * test_multi_channel_pwm_timer: self-checking bench for the pwm timer.
 * assumes the load model and the bound checker are compiled beside it.
 */
`timescale 1ns/1ps
module test_multi_channel_pwm_timer;
	import mcpwm_pkg::*;
	logic             ref_clk = 1'b0;
	logic             resetn = 1'b0;
	logic [7:0]       avs_address = 8'h00;
	logic             avs_read = 1'b0;
	logic             avs_write = 1'b0;
	logic [31:0]      avs_writedata = 32'h0000_0000;
	logic [31:0]      avs_readdata;
	logic             avs_waitrequest;
	logic [1:0]       cap_in = 2'h0;
	logic [6:1]       pwm_out;
	logic             irq;
	logic [6:1][31:0] per_q;
	logic [6:1][31:0] hi_q;
	int               mismatches = 0;
	int               check_count = 0;
	always #12.5 ref_clk = ~ref_clk;
	mcpwm_top i_dut (.ref_clk, .resetn, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_readdata, .avs_waitrequest, .cap_in, .pwm_out, .irq);
	mcpwm_load i_load (.ref_clk, .pwm_out, .per_q, .hi_q);
	////////////////////////////////////////////////////////////////////////////
	task automatic test_done;
		if (mismatches == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 50);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		chk({31'h0, n < 50}, 32'h0000_0001);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		chk(q, exp);
	endtask
	function automatic logic [7:0] mo(input int i);
		return MCPWM_MATCH0_OFS + 8'(4 * i);
	endfunction
	task automatic setup(input logic [31:0] pre, m1, m2, m3, sel);
		wr(MCPWM_CTRL_OFS, 32'h0000_0000);
		wr(MCPWM_CTRL_OFS, 32'h0000_0002);
		wr(MCPWM_PRESCALE_OFS, pre);
		wr(mo(0), 32'h0000_0009);
		wr(mo(1), m1);
		wr(mo(2), m2);
		wr(mo(3), m3);
		wr(MCPWM_ACTION_OFS, 32'h0000_0000);
		wr(MCPWM_OUTSEL_OFS, sel);
		wr(MCPWM_CTRL_OFS, 32'h0000_0005);
	endtask
	task automatic pulse(input logic [1:0] m, input int k);
		repeat (k)
		begin
			cap_in <= m;
			repeat (4) @(posedge ref_clk);
			cap_in <= 2'h0;
			repeat (4) @(posedge ref_clk);
		end
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		rd(MCPWM_CTRL_OFS, 32'h0000_0000);
		rd(MCPWM_STATUS_OFS, 32'h0000_0000);
		wr(8'h40, 32'hFFFF_FFFF);
		rd(8'h40, 32'h0000_0000);
		wr(mo(6), 32'h1234_5678);
		rd(mo(6), 32'h1234_5678);
	endtask
	task automatic t_single(input logic [31:0] pre);
		setup(pre, 32'h0000_0003, 32'h0000_0000, 32'h0000_0000, 32'h0000_0600);
		repeat (45 * (pre + 1)) @(posedge ref_clk);
		chk(per_q[1], 10 * (pre + 1));
		chk(hi_q[1], 4 * (pre + 1));
		chk(hi_q[2] | per_q[2], 32'h0000_0000);
	endtask
	task automatic t_release;
		wr(mo(1), 32'h0000_0006);
		repeat (30) @(posedge ref_clk);
		chk(hi_q[1], 32'h0000_0004);
		wr(MCPWM_RELEASE_OFS, 32'h0000_0002);
		repeat (35) @(posedge ref_clk);
		chk(hi_q[1], 32'h0000_0007);
	endtask
	task automatic t_double;
		logic [31:0] rise;
		logic [31:0] fall;
		for (int i = 0; i < 2; i++)
		begin
			rise = i ? 32'h0000_0007 : 32'h0000_0001;
			fall = i ? 32'h0000_0001 : 32'h0000_0007;
			setup(32'h0000_0000, 32'h0000_0003, rise, fall, 32'h0000_0A08);
			repeat (45) @(posedge ref_clk);
			chk(per_q[3], 32'h0000_000A);
			chk(hi_q[3], (fall - rise + 32'h0000_000A) % 32'h0000_000A);
			chk(hi_q[1], 32'h0000_0004);
		end
	endtask
	task automatic t_timer;
		logic [31:0] q;
		setup(32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
		wr(MCPWM_CTRL_OFS, 32'h0000_0000);
		wr(mo(0), 32'h0000_0005);
		wr(MCPWM_ACTION_OFS, 32'h0000_0005);
		wr(MCPWM_CTRL_OFS, 32'h0000_0001);
		repeat (20) @(posedge ref_clk);
		chk({31'h0, irq}, 32'h0000_0000);
		wr(MCPWM_MASK_OFS, 32'h0000_0001);
		repeat (3) @(posedge ref_clk);
		chk({31'h0, irq}, 32'h0000_0001);
		rd(MCPWM_STATUS_OFS, 32'h0000_0001);
		repeat (3) @(posedge ref_clk);
		chk({31'h0, irq}, 32'h0000_0000);
		rd(MCPWM_CTRL_OFS, 32'h0000_0000);
		chk({26'h0, pwm_out}, 32'h0000_0000);
		for (int i = 0; i < 2; i++)
		begin
			wr(MCPWM_ACTION_OFS, i ? 32'h0000_0003 : 32'h0000_0001);
			wr(MCPWM_COUNT_OFS, 32'h0000_0000);
			wr(MCPWM_CTRL_OFS, 32'h0000_0001);
			repeat (20) @(posedge ref_clk);
			bus(1'b0, MCPWM_COUNT_OFS, 32'h0000_0000, q);
			chk({31'h0, q > 32'h0000_0005}, i ? 32'h0000_0000 : 32'h0000_0001);
			rd(MCPWM_STATUS_OFS, 32'h0000_0001);
		end
	endtask
	task automatic t_counter;
		wr(MCPWM_CTRL_OFS, 32'h0000_0000);
		wr(MCPWM_ACTION_OFS, 32'h0000_0000);
		wr(MCPWM_CTRL_OFS, 32'h0000_0002);
		wr(MCPWM_CTRL_OFS, 32'h0000_0009);
		pulse(2'h1, 5);
		wr(MCPWM_CTRL_OFS, 32'h0000_0029);
		pulse(2'h2, 3);
		pulse(2'h1, 2);
		repeat (6) @(posedge ref_clk);
		rd(MCPWM_COUNT_OFS, 32'h0000_0008);
		wr(MCPWM_CTRL_OFS, 32'h0000_0019);
		pulse(2'h1, 2);
		wr(MCPWM_CTRL_OFS, 32'h0000_0011);
		pulse(2'h1, 1);
		rd(MCPWM_COUNT_OFS, 32'h0000_000D);
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		mismatches++;
		test_done;
	end
	initial
	begin
		repeat (20) @(posedge ref_clk);
		resetn <= 1'b1;
		t_regs;
		t_single(32'h0000_0002);
		t_single(32'h0000_0000);
		t_release;
		t_double;
		t_timer;
		t_counter;
		test_done;
	end
endmodule
